// File: uart_shadow_pkg.sv
// Purpose: shared constants and types for the serial data-port alias block
// Assumes: AHB-Lite, 32-bit data, one aligned word per register
// Notes: all sixteen aliases decode to one data path

package uart_shadow_pkg;

    // documented alias locations, each a byte address
    localparam logic [31:0] SHADOW_PORT5_ADDR = 32'h5000_1044;
    localparam logic [31:0] SHADOW_PORT6_ADDR = 32'h5000_1048;
    localparam int SHADOW_PORT_COUNT = 16;
    localparam logic [31:0] SHADOW_PORT_STRIDE = 32'h0000_0004;
    localparam logic [31:0] SHADOW_BASE_ADDR = SHADOW_PORT5_ADDR - 32'h0000_0014;
    localparam logic [31:0] SHADOW_LAST_ADDR =
        SHADOW_BASE_ADDR + SHADOW_PORT_STRIDE * (SHADOW_PORT_COUNT - 1);

    // control, status and interrupt registers
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1100;
    localparam logic [31:0] STATUS_ADDR = 32'h5000_1104;
    localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_1108;
    localparam logic [31:0] INT_MASK_ADDR = 32'h5000_110c;

    // field positions
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_IR_MODE_BIT = 1;
    localparam int STAT_DATA_READY_BIT = 0;
    localparam int STAT_TX_EMPTY_BIT = 5;
    localparam int STAT_TX_FULL_BIT = 6;
    localparam int STAT_RX_FULL_BIT = 7;
    localparam int INT_RX_BIT = 0;
    localparam int INT_OVERRUN_BIT = 1;
    localparam int INT_TX_EMPTY_BIT = 2;
    localparam int INT_WIDTH = 3;

    // widths and reset values
    localparam int DATA_WIDTH = 8;
    localparam int FIFO_DEPTH_DEFAULT = 16;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [INT_WIDTH-1:0] INT_RESET = 3'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_BUSY = 2'b10
    } bus_state_t;

endpackage

// File: fifo_mem.sv
// Purpose: byte storage for one FIFO, registered read port
// Assumes: DEPTH is a power of two
// Notes: read data lag the address by one clock

`timescale 1ns/1ps

module fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read port
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdData;
    } mem_state_t;

    mem_state_t memState_reg;
    mem_state_t memState_next;

    always_comb begin
        memState_next = memState_reg;
        // read sees the array before this edge's write
        memState_next.rdData = memState_reg.mem[rdAddr];
        if (wrEn) begin
            memState_next.mem[wrAddr] = wrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            memState_reg <= '0;
        end else begin
            memState_reg <= memState_next;
        end
    end

    assign rdData = memState_reg.rdData;

endmodule

// File: uart_shadow_data_port.sv
// Purpose: shadow receive/transmit data-port aliases of a serial controller
// Assumes: framing logic on clk_sys delivers and takes whole bytes
// Notes: FIFO storage has registered reads, so bus reads of the data
//        port wait until the receive head has settled
//
// Design decision made here: the AHB-Lite register port.

`timescale 1ns/1ps

// How it works
// - sixteen word aliases share one data path
// - read returns byte from active input
// - no FIFO: new byte overwrites, flags overrun
// - FIFO on: read returns oldest receive entry
// - full receive FIFO drops byte, flags overrun
// - written byte goes to active serial output
// - no FIFO: one write clears holding empty
// - no FIFO: later write replaces pending byte
// - FIFO on: accepts writes up to depth
// - write to full transmit FIFO is dropped
module uart_shadow_data_port import uart_shadow_pkg::*; #(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // received bytes from the framing logic
    input wire logic stdRxValid,
    input wire logic [7:0] stdRxByte,
    input wire logic irRxValid,
    input wire logic [7:0] irRxByte,
    // bytes towards the serializers
    output logic [7:0] txByte,
    output logic txStdValid,
    output logic txIrValid,
    input wire logic txReady,
    // line status and interrupt
    output logic rxDataReady,
    output logic txHoldingEmpty,
    output logic rxOverrun,
    output logic irq
);

    localparam int AW = $clog2(FIFO_DEPTH);
    // counts carry one bit more than pointers to tell full from empty
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(FIFO_DEPTH);

    typedef struct packed {
        bus_state_t busState;
        logic [31:0] accAddr;
        logic accWrite;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic fifoEnable;
        logic irMode;
        logic [7:0] rxHold;
        logic rxHoldFull;
        logic [AW-1:0] rxHead;
        logic [AW-1:0] rxTail;
        logic [AW:0] rxCount;
        logic rxSettle;
        logic [AW-1:0] txHead;
        logic [AW-1:0] txTail;
        logic [AW:0] txCount;
        logic txSettle;
        logic [7:0] txByte;
        logic txStdValid;
        logic txIrValid;
        logic rxDataReady;
        logic txEmpty;
        logic rxOverrun;
        logic [INT_WIDTH-1:0] intStatus;
        logic [INT_WIDTH-1:0] intMask;
        logic irq;
    } port_state_t;

    port_state_t state_reg;
    port_state_t state_next;

    logic [7:0] rxRdData;
    logic [7:0] txRdData;
    logic rxWrEn;
    logic txWrEn;
    logic rxPush;
    logic rxPop;
    logic txPush;
    logic txPop;
    logic flush;
    logic lineValid;
    logic [7:0] lineByte;
    logic isShadow;
    logic [INT_WIDTH-1:0] events;
    logic [31:0] statusWord;
    logic holdTaken;

    fifo_mem #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) rxMem (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wrEn(rxWrEn),
        .wrAddr(state_reg.rxTail),
        .wrData(lineByte),
        .rdAddr(state_reg.rxHead),
        .rdData(rxRdData)
    );

    fifo_mem #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) txMem (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wrEn(txWrEn),
        .wrAddr(state_reg.txTail),
        .wrData(hwdata[7:0]),
        .rdAddr(state_reg.txHead),
        .rdData(txRdData)
    );

    // every aligned alias lands on the same data path
    assign isShadow = (state_reg.accAddr >= SHADOW_BASE_ADDR)
        && (state_reg.accAddr <= SHADOW_LAST_ADDR)
        && (state_reg.accAddr[1:0] == 2'h0);

    // the active mode picks the receive source
    assign lineValid = state_reg.irMode ? irRxValid : stdRxValid;
    assign lineByte = state_reg.irMode ? irRxByte : stdRxByte;

    // a data-port read ending this cycle hands out the holding byte
    assign holdTaken = (state_reg.busState == BUS_BUSY) && !state_reg.accWrite && isShadow
        && !state_reg.rxSettle && !state_reg.fifoEnable;

    // full flags only mean anything with the FIFOs on
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[STAT_DATA_READY_BIT] = state_reg.rxDataReady;
        statusWord[STAT_TX_EMPTY_BIT] = state_reg.txEmpty;
        statusWord[STAT_TX_FULL_BIT] = state_reg.fifoEnable && (state_reg.txCount == FULL_COUNT);
        statusWord[STAT_RX_FULL_BIT] = state_reg.fifoEnable && (state_reg.rxCount == FULL_COUNT);
    end

    always_comb begin
        state_next = state_reg;
        // overrun is a one-cycle pulse
        state_next.rxOverrun = 1'b0;
        rxWrEn = 1'b0;
        txWrEn = 1'b0;
        rxPush = 1'b0;
        rxPop = 1'b0;
        txPush = 1'b0;
        txPop = 1'b0;
        flush = 1'b0;
        events = '0;

        // serializer took the presented byte
        if ((state_reg.txStdValid || state_reg.txIrValid) && txReady) begin
            state_next.txStdValid = 1'b0;
            state_next.txIrValid = 1'b0;
        end

        // refill from the transmit FIFO once its head has settled
        if (state_reg.fifoEnable && !state_next.txStdValid && !state_next.txIrValid
            && (state_reg.txCount != '0) && !state_reg.txSettle) begin
            state_next.txByte = txRdData;
            state_next.txStdValid = !state_reg.irMode;
            state_next.txIrValid = state_reg.irMode;
            state_next.txHead = state_reg.txHead + 1'b1;
            txPop = 1'b1;
        end

        // receive side
        if (lineValid) begin
            if (state_reg.fifoEnable) begin
                if (state_reg.rxCount == FULL_COUNT) begin
                    // keep what is stored, lose the newcomer
                    state_next.rxOverrun = 1'b1;
                end else begin
                    rxWrEn = 1'b1;
                    rxPush = 1'b1;
                    state_next.rxTail = state_reg.rxTail + 1'b1;
                end
            end else begin
                if (state_reg.rxHoldFull && !holdTaken) begin
                    state_next.rxOverrun = 1'b1;
                end
                state_next.rxHold = lineByte;
                state_next.rxHoldFull = 1'b1;
            end
            events[INT_RX_BIT] = rxPush || !state_reg.fifoEnable;
        end

        // bus slave
        case (state_reg.busState)
            BUS_IDLE: begin
                // no zero-wait transfers: every data phase gets a wait state
                if (hsel && htrans[1] && hready) begin
                    state_next.accAddr = haddr;
                    state_next.accWrite = hwrite;
                    state_next.busState = BUS_BUSY;
                    state_next.hreadyout = 1'b0;
                end
            end
            BUS_BUSY: begin
                if (state_reg.accWrite) begin
                    state_next.busState = BUS_IDLE;
                    state_next.hreadyout = 1'b1;
                    if (isShadow) begin
                        if (state_reg.fifoEnable) begin
                            if (state_reg.txCount != FULL_COUNT) begin
                                txWrEn = 1'b1;
                                txPush = 1'b1;
                                state_next.txTail = state_reg.txTail + 1'b1;
                            end
                            // full: the byte is simply dropped
                        end else begin
                            // holding byte is replaced while still pending
                            state_next.txByte = hwdata[7:0];
                            state_next.txStdValid = !state_reg.irMode;
                            state_next.txIrValid = state_reg.irMode;
                        end
                    end else if (state_reg.accAddr == CTRL_ADDR) begin
                        state_next.fifoEnable = hwdata[CTRL_FIFO_EN_BIT];
                        state_next.irMode = hwdata[CTRL_IR_MODE_BIT];
                        flush = hwdata[CTRL_FIFO_EN_BIT] != state_reg.fifoEnable;
                    end else if (state_reg.accAddr == INT_STATUS_ADDR) begin
                        state_next.intStatus = state_reg.intStatus & ~hwdata[INT_WIDTH-1:0];
                    end else if (state_reg.accAddr == INT_MASK_ADDR) begin
                        state_next.intMask = hwdata[INT_WIDTH-1:0];
                    end
                end else if (!(isShadow && state_reg.rxSettle)) begin
                    // reads of the data port wait for a settled head
                    state_next.busState = BUS_IDLE;
                    state_next.hreadyout = 1'b1;
                    state_next.hrdata = 32'h0000_0000;
                    if (isShadow) begin
                        if (state_reg.fifoEnable) begin
                            state_next.hrdata = {24'h00_0000, rxRdData};
                            if (state_reg.rxCount != '0) begin
                                rxPop = 1'b1;
                                state_next.rxHead = state_reg.rxHead + 1'b1;
                            end
                        end else begin
                            state_next.hrdata = {24'h00_0000, state_reg.rxHold};
                            // a byte landing on this edge stays pending, set beats clear
                            state_next.rxHoldFull = lineValid;
                        end
                    end else if (state_reg.accAddr == CTRL_ADDR) begin
                        state_next.hrdata[CTRL_FIFO_EN_BIT] = state_reg.fifoEnable;
                        state_next.hrdata[CTRL_IR_MODE_BIT] = state_reg.irMode;
                    end else if (state_reg.accAddr == STATUS_ADDR) begin
                        state_next.hrdata = statusWord;
                    end else if (state_reg.accAddr == INT_STATUS_ADDR) begin
                        state_next.hrdata[INT_WIDTH-1:0] = state_reg.intStatus;
                    end else if (state_reg.accAddr == INT_MASK_ADDR) begin
                        state_next.hrdata[INT_WIDTH-1:0] = state_reg.intMask;
                    end
                end
            end
            default: begin
                state_next.busState = BUS_IDLE;
                state_next.hreadyout = 1'b1;
            end
        endcase

        // pointer and count bookkeeping
        state_next.rxCount = state_reg.rxCount + (AW + 1)'(rxPush) - (AW + 1)'(rxPop);
        state_next.txCount = state_reg.txCount + (AW + 1)'(txPush) - (AW + 1)'(txPop);
        // registered read ports lag a pointer move by one cycle
        state_next.rxSettle = rxPush || rxPop;
        state_next.txSettle = txPush || txPop;

        // a FIFO-enable change empties both FIFOs and the receive holding flag; an IR mode change does not
        if (flush) begin
            state_next.rxHead = '0;
            state_next.rxTail = '0;
            state_next.rxCount = '0;
            state_next.txHead = '0;
            state_next.txTail = '0;
            state_next.txCount = '0;
            state_next.rxHoldFull = 1'b0;
            state_next.rxSettle = 1'b1;
            state_next.txSettle = 1'b1;
        end

        // line-status view
        state_next.rxDataReady = state_next.fifoEnable
            ? (state_next.rxCount != '0) : state_next.rxHoldFull;
        state_next.txEmpty = state_next.fifoEnable
            ? (state_next.txCount == '0)
            : !(state_next.txStdValid || state_next.txIrValid);

        // sticky events, a new event beats a same-cycle clear
        events[INT_OVERRUN_BIT] = state_next.rxOverrun;
        events[INT_TX_EMPTY_BIT] = state_next.txEmpty && !state_reg.txEmpty;
        state_next.intStatus = state_next.intStatus | events;
        state_next.irq = |(state_next.intStatus & state_next.intMask);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            // fields not named below reset to zero
            state_reg <= '0;
            state_reg.busState <= BUS_IDLE;
            state_reg.hreadyout <= 1'b1;
            state_reg.rxHold <= DATA_RESET;
            state_reg.txByte <= DATA_RESET;
            state_reg.txEmpty <= 1'b1;
            state_reg.intStatus <= INT_RESET;
            state_reg.intMask <= INT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hreadyout = state_reg.hreadyout;
    assign hresp = state_reg.hresp;
    assign hrdata = state_reg.hrdata;
    assign txByte = state_reg.txByte;
    assign txStdValid = state_reg.txStdValid;
    assign txIrValid = state_reg.txIrValid;
    assign rxDataReady = state_reg.rxDataReady;
    assign txHoldingEmpty = state_reg.txEmpty;
    assign rxOverrun = state_reg.rxOverrun;
    assign irq = state_reg.irq;

endmodule

// File: uart_shadow_checker.sv
// Purpose: port-level checks of the data-port alias block
// Assumes: one slave, hready tied to hreadyout
// Notes: mode and FIFO state are internal, so checks stay mode-free
`timescale 1ns/1ps
module uart_shadow_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // line side
    input wire logic stdRxValid,
    input wire logic irRxValid,
    input wire logic [7:0] txByte,
    input wire logic txStdValid,
    input wire logic txIrValid,
    input wire logic txReady,
    input wire logic rxDataReady,
    input wire logic txHoldingEmpty,
    input wire logic rxOverrun,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_take(w);
        hsel && htrans[1] && hready && hreadyout && hwrite == w;
    endsequence
    sequence s_wait;
        !hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_write_wait: assert property (s_take(1'b1) |=> s_wait ##1 hreadyout)
        else $error("write wait not one cycle");
    a_read_bound: assert property (s_take(1'b0) |=> s_wait ##[1:20] hreadyout)
        else $error("read never completed");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ready_cause: assert property ($rose(rxDataReady) |-> $past(stdRxValid || irRxValid))
        else $error("data ready without a byte");
    a_overrun_cause: assert property (rxOverrun |-> $past(stdRxValid || irRxValid))
        else $error("overrun without a byte");
    a_tx_one_mode: assert property (!(txStdValid && txIrValid))
        else $error("both serializers offered");
    a_tx_held: assert property ((txStdValid || txIrValid) && !txReady |=> txStdValid || txIrValid)
        else $error("offered byte withdrawn");
    a_reset_state: assert property (disable iff (1'b0) !rst_b |=> hreadyout && !rxDataReady
        && txHoldingEmpty && !irq && txByte == 8'h00)
        else $error("reset values wrong");
endmodule

bind uart_shadow_data_port uart_shadow_checker i_uart_shadow_checker (.clk_sys(clk_sys),
    .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stdRxValid(stdRxValid),
    .irRxValid(irRxValid), .txByte(txByte), .txStdValid(txStdValid), .txIrValid(txIrValid),
    .txReady(txReady), .rxDataReady(rxDataReady), .txHoldingEmpty(txHoldingEmpty),
    .rxOverrun(rxOverrun), .irq(irq));

// File: uart_line_partner.sv
// Purpose: far-side framing model, delivers bytes and takes tx bytes
// Assumes: bench asks for each received byte
// Notes: idle byte lines show the inverse of the last byte
`timescale 1ns/1ps
module uart_line_partner (
    // clock
    input wire logic clk_sys,
    // bench requests
    input wire logic sendReq,
    input wire logic sendIr,
    input wire logic [7:0] sendByte,
    input wire logic hold,
    // design side
    output logic stdRxValid,
    output logic [7:0] stdRxByte,
    output logic irRxValid,
    output logic [7:0] irRxByte,
    output logic txReady
);
    logic [7:0] lastByte = 8'h00;
    always_ff @(posedge clk_sys) begin
        if (sendReq) begin
            lastByte <= sendByte;
        end
        // hold models a slow serializer
        txReady <= !hold;
    end
    assign stdRxValid = sendReq && !sendIr;
    assign irRxValid = sendReq && sendIr;
    assign stdRxByte = stdRxValid ? sendByte : ~lastByte;
    assign irRxByte = irRxValid ? sendByte : ~lastByte;
endmodule

// File: uart_shadow_data_port_bench.sv
// Purpose: self-checking bench for the data-port alias block
// Assumes: FIFO depth cut to 4 so fill tests stay short
// Notes: drivers queue expectations, a monitor pops them on results
`timescale 1ns/1ps
module uart_shadow_data_port_bench import uart_shadow_pkg::*;;
    localparam int DEPTH = 4;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, stdRxValid, irRxValid, txStdValid, txIrValid, txReady;
    logic [31:0] hrdata;
    logic [7:0] stdRxByte, irRxByte, txByte;
    logic rxDataReady, txHoldingEmpty, rxOverrun, irq;
    logic sendReq = 1'b0, sendIr = 1'b0, hold = 1'b0, inRd = 1'b0;
    logic [7:0] sendByte = 8'h00;
    logic [31:0] expRd[$];
    logic [8:0] expTx[$];
    int error_cnt = 0, compares = 0, ovCnt = 0;
    initial forever #12.5 clk_sys = ~clk_sys;
    uart_shadow_data_port #(.FIFO_DEPTH(DEPTH)) i_uart_shadow_data_port (.clk_sys(clk_sys),
        .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .stdRxValid(stdRxValid), .stdRxByte(stdRxByte),
        .irRxValid(irRxValid), .irRxByte(irRxByte), .txByte(txByte), .txStdValid(txStdValid),
        .txIrValid(txIrValid), .txReady(txReady), .rxDataReady(rxDataReady),
        .txHoldingEmpty(txHoldingEmpty), .rxOverrun(rxOverrun), .irq(irq));
    uart_line_partner i_uart_line_partner (.clk_sys(clk_sys), .sendReq(sendReq),
        .sendIr(sendIr), .sendByte(sendByte), .hold(hold), .stdRxValid(stdRxValid),
        .stdRxByte(stdRxByte), .irRxValid(irRxValid), .irRxByte(irRxByte), .txReady(txReady));
    task automatic print_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic bit cond(input int w);
        case (w)
            0: return rxDataReady === 1'b1;
            1: return (txStdValid | txIrValid) === 1'b1;
            2: return txHoldingEmpty === 1'b1;
            3: return expTx.size() == 0;
            4: return irq === 1'b1;
            default: return irq === 1'b0;
        endcase
    endfunction
    task automatic waitOn(input int w);
        int n;
        n = 0;
        while (!cond(w) && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 100) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    task automatic untilReady();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        untilReady();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        untilReady();
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expRd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // random alias and random upper bits on every data-port write
    task automatic send(input logic ir, input logic [7:0] b, input bit keep);
        if (keep) begin
            expTx.push_back({ir, b});
        end
        bus(1'b1, SHADOW_BASE_ADDR + {26'h0, 4'($urandom), 2'b00}, {24'($urandom), b});
    endtask
    task automatic rxSend(input logic ir, input logic [7:0] b);
        sendReq <= 1'b1;
        sendIr <= ir;
        sendByte <= b;
        @(posedge clk_sys);
        sendReq <= 1'b0;
        @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        if (inRd && hreadyout === 1'b1) begin
            chk("hrdata", expRd.pop_front(), hrdata);
        end
        if (hreadyout === 1'b1) begin
            inRd = hsel && htrans[1] && !hwrite;
        end
        if ((txStdValid | txIrValid) === 1'b1 && txReady === 1'b1) begin
            chk("tx", {23'h0, expTx.pop_front()}, {23'h0, txIrValid, txByte});
        end
        if (rxOverrun === 1'b1) begin
            ovCnt++;
        end
    end
    initial begin
        logic [7:0] b[DEPTH+1];
        int ov;
        void'($urandom(80));
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        chk("rxDataReady", 32'h0, {31'h0, rxDataReady});
        rd(STATUS_ADDR, 32'h20);
        rd(SHADOW_PORT5_ADDR, 32'h0);
        bus(1'b1, 32'h5000_1200, 32'hffff_ffff);
        rd(32'h5000_1200, 32'h0);
        bus(1'b1, INT_MASK_ADDR, 32'h1);
        rxSend(1'b0, 8'h5a);
        waitOn(4);
        bus(1'b1, INT_MASK_ADDR, 32'h0);
        waitOn(5);
        rd(INT_STATUS_ADDR, 32'h1);
        bus(1'b1, INT_STATUS_ADDR, 32'h1);
        rd(INT_STATUS_ADDR, 32'h0);
        rd(SHADOW_PORT6_ADDR, 32'h5a);
        for (int i = 0; i < SHADOW_PORT_COUNT; i++) begin
            b[0] = 8'($urandom);
            rxSend(1'b0, b[0]);
            waitOn(0);
            rd(SHADOW_BASE_ADDR + 32'(4 * i), {24'h0, b[0]});
        end
        ov = ovCnt;
        rxSend(1'b0, 8'h11);
        rxSend(1'b0, 8'h22);
        waitOn(0);
        rd(SHADOW_PORT5_ADDR, 32'h22);
        chk("overrun", ov + 1, ovCnt);
        hold <= 1'b1;
        send(1'b0, 8'ha1, 0);
        chk("txHoldingEmpty", 32'h0, {31'h0, txHoldingEmpty});
        send(1'b0, 8'hb2, 1);
        hold <= 1'b0;
        waitOn(3);
        waitOn(2);
        bus(1'b1, CTRL_ADDR, 32'h2);
        rxSend(1'b0, 8'h33);
        rxSend(1'b1, 8'hc4);
        waitOn(0);
        rd(SHADOW_PORT6_ADDR, 32'hc4);
        send(1'b1, 8'h9e, 1);
        waitOn(3);
        bus(1'b1, CTRL_ADDR, 32'h1);
        ov = ovCnt;
        for (int i = 0; i <= DEPTH; i++) begin
            b[i] = 8'($urandom);
            rxSend(1'b0, b[i]);
        end
        @(posedge clk_sys);
        chk("overrun", ov + 1, ovCnt);
        rd(STATUS_ADDR, 32'ha1);
        rd(INT_STATUS_ADDR, 32'h7);
        for (int i = 0; i < DEPTH; i++) begin
            rd(SHADOW_BASE_ADDR + 32'(4 * i), {24'h0, b[i]});
        end
        // first byte parks in the serializer so the FIFO fill is exact
        hold <= 1'b1;
        send(1'b0, 8'h01, 1);
        waitOn(1);
        for (int i = 0; i <= DEPTH; i++) begin
            send(1'b0, 8'(8'h10 + i), i < DEPTH);
        end
        rd(STATUS_ADDR, 32'h40);
        hold <= 1'b0;
        waitOn(3);
        print_verdict();
    end
endmodule
